// *** verilog/csr_status_reg.sv ***
// Core status register: wake causes, program page select, reset status and
// ALU flags. Assumes the instruction decoder, watchdog and sleep logic drive
// the event pulses on core_clk_in, one cycle each.
`timescale 1ns/10ps
module csr_status_reg
  import csr_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  input wire logic [7:0] file_addr_in,
  input wire logic file_wr_en_in,
  input wire logic [7:0] file_wr_data_in,
  input wire csr_op_t alu_op_in,
  input wire logic [7:0] alu_operand_f_in,
  input wire logic [7:0] alu_operand_w_in,
  input wire logic reset_event_in,
  input wire csr_wake_cause_t reset_cause_in,
  input wire logic watchdog_timeout_in,
  input wire logic watchdog_clear_instr_in,
  input wire logic sleep_instr_in,
  output logic [7:0] status_out,
  output logic [7:0] alu_result_out,
  output logic [9:0] page_base_out
);

  // ****************************************
  // Flag unit
  // ****************************************
  csr_alu_if alu_bus ();
  csr_state_t st_r;
  csr_state_t st_nxt;
  logic [7:0] result_r;
  logic wr_hit;

  assign alu_bus.op = alu_op_in;
  assign alu_bus.operand_f = alu_operand_f_in;
  assign alu_bus.operand_w = alu_operand_w_in;
  assign alu_bus.carry_in = st_r.carry;

  csr_alu_flags u_flags (
    .bus(alu_bus.alu)
  );

  assign wr_hit = file_wr_en_in && (file_addr_in == CSR_STATUS_ADDR);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    if (wr_hit) begin
      st_nxt.pin_change_wake_flag = file_wr_data_in[CSR_BIT_PIN_WAKE];
      st_nxt.comparator_wake_flag = file_wr_data_in[CSR_BIT_CMP_WAKE];
      st_nxt.program_page_select = file_wr_data_in[CSR_BIT_PAGE];
      // Only flags the instruction leaves alone take the write
      if (!alu_bus.upd_zero) begin
        st_nxt.zero = file_wr_data_in[CSR_BIT_ZERO];
      end
      if (!alu_bus.upd_nibble) begin
        st_nxt.nibble_overflow_bit = file_wr_data_in[CSR_BIT_NIBBLE];
      end
      if (!alu_bus.upd_carry) begin
        st_nxt.carry = file_wr_data_in[CSR_BIT_CARRY];
      end
      // Expiry and sleep flags are never written
    end
    if (alu_bus.upd_zero) begin
      st_nxt.zero = alu_bus.zero;
    end
    if (alu_bus.upd_nibble) begin
      st_nxt.nibble_overflow_bit = alu_bus.nibble;
    end
    if (alu_bus.upd_carry) begin
      st_nxt.carry = alu_bus.carry;
    end
    // Reset cause beats a software write in the same cycle
    if (reset_event_in) begin
      st_nxt.pin_change_wake_flag = (reset_cause_in == CSR_CAUSE_PIN);
      st_nxt.comparator_wake_flag = (reset_cause_in == CSR_CAUSE_CMP);
    end
    if (watchdog_clear_instr_in) begin
      st_nxt.watchdog_expiry_flag = 1'b1;
      st_nxt.sleep_entered_flag = 1'b1;
    end
    if (sleep_instr_in) begin
      st_nxt.watchdog_expiry_flag = 1'b1;
      st_nxt.sleep_entered_flag = 1'b0;
    end
    // A time-out is the last word so that it is never lost
    if (watchdog_timeout_in) begin
      st_nxt.watchdog_expiry_flag = 1'b0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_r <= CSR_STATUS_RESET;
      result_r <= CSR_RESULT_RESET;
    end else if (clk_en_in) begin
      st_r <= st_nxt;
      result_r <= alu_bus.result;
    end
  end

  assign status_out = st_r;
  assign alu_result_out = result_r;
  // Page select is software's alone; used as scratch it redirects jumps
  assign page_base_out = st_r.program_page_select ? CSR_PAGE_UPPER_BASE
                                                  : CSR_PAGE_LOWER_BASE;

  // ****************************************
  // Checks
  // ****************************************
  logic [8:0] chk_add;
  logic [4:0] chk_add_low;
  logic [8:0] chk_sub;
  logic quiet;

  assign chk_add = {1'b0, alu_operand_f_in} + {1'b0, alu_operand_w_in};
  assign chk_add_low = {1'b0, alu_operand_f_in[3:0]} + {1'b0, alu_operand_w_in[3:0]};
  assign chk_sub = {1'b0, alu_operand_f_in} - {1'b0, alu_operand_w_in};
  assign quiet = !reset_event_in && !watchdog_timeout_in && !watchdog_clear_instr_in
                 && !sleep_instr_in;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  // ****************************************
  // Reset causes, page select, expiry and sleep flags, reset value
  // ****************************************
  chk_pin_wake: assert property (
    clk_en_in && reset_event_in && reset_cause_in == CSR_CAUSE_PIN
    |=> status_out[CSR_BIT_PIN_WAKE] && !status_out[CSR_BIT_CMP_WAKE])
    else $error("pin wake flag not set by pin wake reset");
  chk_cmp_wake: assert property (
    clk_en_in && reset_event_in && reset_cause_in == CSR_CAUSE_CMP
    |=> status_out[CSR_BIT_CMP_WAKE] && !status_out[CSR_BIT_PIN_WAKE])
    else $error("comparator wake flag not set by comparator wake reset");
  chk_other_wake: assert property (
    clk_en_in && reset_event_in && reset_cause_in == CSR_CAUSE_OTHER
    |=> !status_out[CSR_BIT_PIN_WAKE] && !status_out[CSR_BIT_CMP_WAKE])
    else $error("wake flags not cleared by other reset");
  chk_page_base: assert property (
    page_base_out == (status_out[CSR_BIT_PAGE] ? 10'h200 : 10'h000))
    else $error("page base does not follow page select");
  chk_page_write: assert property (
    clk_en_in && wr_hit
    |=> status_out[CSR_BIT_PAGE] == $past(file_wr_data_in[CSR_BIT_PAGE]))
    else $error("page select did not take the written value");
  chk_timeout_clear: assert property (
    clk_en_in && watchdog_timeout_in
    |=> !status_out[CSR_BIT_EXPIRY])
    else $error("expiry flag not cleared by time-out");
  chk_sleep_entry: assert property (
    clk_en_in && sleep_instr_in && !watchdog_timeout_in
    |=> status_out[CSR_BIT_EXPIRY] && !status_out[CSR_BIT_SLEEP])
    else $error("sleep did not set expiry and clear sleep flag");
  chk_clear_sets: assert property (
    clk_en_in && watchdog_clear_instr_in && !sleep_instr_in && !watchdog_timeout_in
    |=> status_out[CSR_BIT_EXPIRY] && status_out[CSR_BIT_SLEEP])
    else $error("watchdog clear did not set expiry and sleep flags");
  // Reset must be seen even though every other check is off during it
  chk_reset_value: assert property (
    disable iff (1'b0) srst_in
    |=> status_out == CSR_STATUS_RESET && alu_result_out == CSR_RESULT_RESET)
    else $error("register not at reset value after reset");

  // ****************************************
  // Arithmetic flags
  // ****************************************
  chk_zero_flag: assert property (
    clk_en_in && alu_op_in == CSR_OP_ADD
    |=> status_out[CSR_BIT_ZERO] == ($past(chk_add[7:0]) == 8'h00))
    else $error("zero flag wrong after add");
  chk_logic_zero: assert property (
    clk_en_in && alu_op_in == CSR_OP_XOR
    |=> status_out[CSR_BIT_ZERO] == ($past(alu_operand_f_in) == $past(alu_operand_w_in)))
    else $error("zero flag wrong after exclusive or");
  chk_add_flags: assert property (
    clk_en_in && alu_op_in == CSR_OP_ADD
    |=> status_out[CSR_BIT_CARRY] == $past(chk_add[8])
        && status_out[CSR_BIT_NIBBLE] == $past(chk_add_low[4]))
    else $error("add carry or nibble flag wrong");
  chk_sub_borrow: assert property (
    clk_en_in && alu_op_in == CSR_OP_SUB
    |=> status_out[CSR_BIT_CARRY] == !$past(chk_sub[8]))
    else $error("subtract carry is not inverted borrow");
  chk_sub_nibble: assert property (
    clk_en_in && alu_op_in == CSR_OP_SUB
    |=> status_out[CSR_BIT_NIBBLE]
        == ($past(alu_operand_f_in[3:0]) >= $past(alu_operand_w_in[3:0])))
    else $error("subtract nibble bit is not inverted borrow");
  chk_rotate_right: assert property (
    clk_en_in && alu_op_in == CSR_OP_RRF
    |=> status_out[CSR_BIT_CARRY] == $past(alu_operand_f_in[0])
        && alu_result_out[7] == $past(status_out[CSR_BIT_CARRY]))
    else $error("rotate right carry wrong");
  chk_rotate_left: assert property (
    clk_en_in && alu_op_in == CSR_OP_RLF
    |=> status_out[CSR_BIT_CARRY] == $past(alu_operand_f_in[7])
        && alu_result_out[0] == $past(status_out[CSR_BIT_CARRY]))
    else $error("rotate left carry wrong");

  // ****************************************
  // Software writes and clock enable
  // ****************************************
  chk_write_protect: assert property (
    clk_en_in && wr_hit && alu_op_in == CSR_OP_AND
    |=> status_out[CSR_BIT_ZERO] == ($past(alu_operand_f_in & alu_operand_w_in) == 8'h00)
        && status_out[1:0] == $past(file_wr_data_in[1:0]))
    else $error("write overrode a flag that the instruction updates");
  chk_status_wr: assert property (
    clk_en_in && wr_hit && alu_op_in == CSR_OP_NONE && quiet
    |=> status_out[4:3] == $past(status_out[4:3])
        && status_out[2:0] == $past(file_wr_data_in[2:0]))
    else $error("status write handled wrongly");
  chk_foreign_addr: assert property (
    clk_en_in && file_wr_en_in && !wr_hit && alu_op_in == CSR_OP_NONE && quiet
    |=> $stable(status_out))
    else $error("write to another address changed the status");
  chk_enable_freeze: assert property (!clk_en_in |=> $stable(status_out))
    else $error("state moved while clock enable low");

  cov_pin_wake: cover property (reset_event_in && reset_cause_in == CSR_CAUSE_PIN && clk_en_in);
  cov_write_add: cover property (wr_hit && alu_op_in == CSR_OP_ADD && clk_en_in);
  cov_sleep_then_timeout: cover property (sleep_instr_in && clk_en_in ##[1:20]
    watchdog_timeout_in && clk_en_in);
  cov_rotate_left: cover property (alu_op_in == CSR_OP_RLF && clk_en_in);
  cov_sub_borrow: cover property (alu_op_in == CSR_OP_SUB && chk_sub[8] && clk_en_in);

endmodule

// *** common/csr_pkg.sv ***
// Constants, types and state layout shared by the core status register files.
// Assumes one core clock domain; all event inputs come from core logic on that clock.
package csr_pkg;

  // ****************************************
  // Register map and field positions
  // ****************************************
  localparam logic [7:0] CSR_STATUS_ADDR = 8'h03;
  localparam int CSR_BIT_PIN_WAKE = 7;
  localparam int CSR_BIT_CMP_WAKE = 6;
  localparam int CSR_BIT_PAGE = 5;
  localparam int CSR_BIT_EXPIRY = 4;
  localparam int CSR_BIT_SLEEP = 3;
  localparam int CSR_BIT_ZERO = 2;
  localparam int CSR_BIT_NIBBLE = 1;
  localparam int CSR_BIT_CARRY = 0;
  // Unknown arithmetic flags come out of reset as zero
  localparam logic [7:0] CSR_STATUS_RESET = 8'h18;
  localparam logic [7:0] CSR_RESULT_RESET = 8'h00;

  // ****************************************
  // Program pages
  // ****************************************
  localparam int CSR_PAGE_SIZE = 512;
  localparam logic [9:0] CSR_PAGE_LOWER_BASE = 10'h000;
  localparam logic [9:0] CSR_PAGE_UPPER_BASE = 10'h200;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    CSR_OP_NONE, CSR_OP_ADD, CSR_OP_SUB, CSR_OP_RRF, CSR_OP_RLF,
    CSR_OP_AND, CSR_OP_IOR, CSR_OP_XOR, CSR_OP_PASS
  } csr_op_t;

  typedef enum logic [1:0] {
    CSR_CAUSE_OTHER, CSR_CAUSE_PIN, CSR_CAUSE_CMP
  } csr_wake_cause_t;

  typedef struct packed {
    logic pin_change_wake_flag;
    logic comparator_wake_flag;
    logic program_page_select;
    logic watchdog_expiry_flag;
    logic sleep_entered_flag;
    logic zero;
    logic nibble_overflow_bit;
    logic carry;
  } csr_state_t;

endpackage

// *** common/csr_alu_if.sv ***
// Carries one ALU operation and its flag results between the status register
// and its flag unit; purely combinational, same clock domain.
`timescale 1ns/10ps
interface csr_alu_if;
  import csr_pkg::*;
  csr_op_t op;
  logic [7:0] operand_f;
  logic [7:0] operand_w;
  logic carry_in;
  logic [7:0] result;
  logic zero;
  logic nibble;
  logic carry;
  logic upd_zero;
  logic upd_nibble;
  logic upd_carry;

  modport alu (
    input op, operand_f, operand_w, carry_in,
    output result, zero, nibble, carry, upd_zero, upd_nibble, upd_carry
  );
  modport core (
    output op, operand_f, operand_w, carry_in,
    input result, zero, nibble, carry, upd_zero, upd_nibble, upd_carry
  );
endinterface

// *** verilog/csr_alu_flags.sv ***
// Flag unit: computes result and arithmetic flags of one ALU operation.
// Assumes the status register supplies the current carry for rotates.
`timescale 1ns/10ps
module csr_alu_flags
  import csr_pkg::*;
(
  csr_alu_if.alu bus
);

  // ****************************************
  // Flag computation
  // ****************************************
  logic [8:0] wide;
  logic [4:0] low;

  always_comb begin
    wide = 9'h000;
    low = 5'h00;
    bus.result = bus.operand_f;
    bus.nibble = 1'b0;
    bus.carry = bus.carry_in;
    bus.upd_zero = 1'b0;
    bus.upd_nibble = 1'b0;
    bus.upd_carry = 1'b0;
    unique case (bus.op)
      CSR_OP_ADD: begin
        wide = {1'b0, bus.operand_f} + {1'b0, bus.operand_w};
        low = {1'b0, bus.operand_f[3:0]} + {1'b0, bus.operand_w[3:0]};
        bus.result = wide[7:0];
        bus.nibble = low[4];
        bus.carry = wide[8];
        bus.upd_zero = 1'b1;
        bus.upd_nibble = 1'b1;
        bus.upd_carry = 1'b1;
      end
      CSR_OP_SUB: begin
        // Two's complement add: carry out means no borrow
        wide = {1'b0, bus.operand_f} + {1'b0, ~bus.operand_w} + 9'h001;
        low = {1'b0, bus.operand_f[3:0]} + {1'b0, ~bus.operand_w[3:0]} + 5'h01;
        bus.result = wide[7:0];
        bus.nibble = low[4];
        bus.carry = wide[8];
        bus.upd_zero = 1'b1;
        bus.upd_nibble = 1'b1;
        bus.upd_carry = 1'b1;
      end
      CSR_OP_RRF: begin
        bus.result = {bus.carry_in, bus.operand_f[7:1]};
        bus.carry = bus.operand_f[0];
        bus.upd_carry = 1'b1;
      end
      CSR_OP_RLF: begin
        bus.result = {bus.operand_f[6:0], bus.carry_in};
        bus.carry = bus.operand_f[7];
        bus.upd_carry = 1'b1;
      end
      CSR_OP_AND: begin
        bus.result = bus.operand_f & bus.operand_w;
        bus.upd_zero = 1'b1;
      end
      CSR_OP_IOR: begin
        bus.result = bus.operand_f | bus.operand_w;
        bus.upd_zero = 1'b1;
      end
      CSR_OP_XOR: begin
        bus.result = bus.operand_f ^ bus.operand_w;
        bus.upd_zero = 1'b1;
      end
      CSR_OP_PASS: begin
        bus.upd_zero = 1'b1;
      end
      default: begin
        bus.result = bus.operand_f;
      end
    endcase
    bus.zero = (bus.result == 8'h00);
  end

endmodule

// *** verif/tb_csr_status_reg.sv ***
// Self-checking bench for the core status register, with a reference model in tasks.
// Assumes the package constants and a single 20 MHz core clock.
`timescale 1ns/10ps
module tb_csr_status_reg;
  import csr_pkg::*;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic [7:0] file_addr_in = 8'h00;
  logic file_wr_en_in = 1'b0;
  logic [7:0] file_wr_data_in = 8'h00;
  csr_op_t alu_op_in = CSR_OP_NONE;
  logic [7:0] alu_operand_f_in = 8'h00;
  logic [7:0] alu_operand_w_in = 8'h00;
  logic reset_event_in = 1'b0;
  csr_wake_cause_t reset_cause_in = CSR_CAUSE_OTHER;
  logic watchdog_timeout_in = 1'b0;
  logic watchdog_clear_instr_in = 1'b0;
  logic sleep_instr_in = 1'b0;
  logic [7:0] status_out;
  logic [7:0] alu_result_out;
  logic [9:0] page_base_out;
  logic [7:0] exp_st = 8'h18;
  logic [7:0] exp_res = 8'h00;
  logic res_ok = 1'b1;
  logic [31:0] seed = 32'h12;
  int n_errors = 0;
  int cmp_count = 0;

  always #25 core_clk_in = ~core_clk_in;

  csr_status_reg dut (.core_clk_in(core_clk_in), .srst_in(srst_in), .clk_en_in(clk_en_in),
    .file_addr_in(file_addr_in), .file_wr_en_in(file_wr_en_in),
    .file_wr_data_in(file_wr_data_in), .alu_op_in(alu_op_in),
    .alu_operand_f_in(alu_operand_f_in), .alu_operand_w_in(alu_operand_w_in),
    .reset_event_in(reset_event_in), .reset_cause_in(reset_cause_in),
    .watchdog_timeout_in(watchdog_timeout_in),
    .watchdog_clear_instr_in(watchdog_clear_instr_in), .sleep_instr_in(sleep_instr_in),
    .status_out(status_out), .alu_result_out(alu_result_out), .page_base_out(page_base_out));

  // ****************************************
  // Reference model and checks
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s seen=%h exp=%h", $time, what, seen, exp);
    end
  endtask

  // Uses the inputs that the edge just sampled; carry in is the pre-edge carry
  task automatic model();
    logic [8:0] s9;
    logic [4:0] s5;
    logic [7:0] f;
    logic [7:0] w;
    logic [7:0] r;
    logic [7:0] st;
    f = alu_operand_f_in;
    w = alu_operand_w_in;
    r = 8'h00;
    st = exp_st;
    if (srst_in) begin
      exp_st = CSR_STATUS_RESET;
      exp_res = CSR_RESULT_RESET;
      res_ok = 1'b1;
    end else if (clk_en_in) begin
      if (file_wr_en_in && file_addr_in == CSR_STATUS_ADDR) begin
        st[7:5] = file_wr_data_in[7:5];
        st[2:0] = file_wr_data_in[2:0];
      end
      if (reset_event_in) begin
        st[7] = (reset_cause_in == CSR_CAUSE_PIN);
        st[6] = (reset_cause_in == CSR_CAUSE_CMP);
      end
      if (watchdog_clear_instr_in) st[4:3] = 2'b11;
      if (sleep_instr_in) st[4:3] = 2'b10;
      if (watchdog_timeout_in) st[4] = 1'b0;
      res_ok = 1'b1;
      s9 = {1'b0, f} + {1'b0, w};
      s5 = {1'b0, f[3:0]} + {1'b0, w[3:0]};
      case (alu_op_in)
        CSR_OP_ADD: begin r = s9[7:0]; st[0] = s9[8]; st[1] = s5[4]; end
        CSR_OP_SUB: begin r = f - w; st[0] = f >= w; st[1] = f[3:0] >= w[3:0]; end
        CSR_OP_RRF: begin r = {exp_st[0], f[7:1]}; st[0] = f[0]; end
        CSR_OP_RLF: begin r = {f[6:0], exp_st[0]}; st[0] = f[7]; end
        CSR_OP_AND: r = f & w;
        CSR_OP_IOR: r = f | w;
        CSR_OP_XOR: r = f ^ w;
        CSR_OP_PASS: r = f;
        default: res_ok = 1'b0;
      endcase
      if (res_ok && alu_op_in != CSR_OP_RRF && alu_op_in != CSR_OP_RLF) begin
        st[2] = (r == 8'h00);
      end
      exp_st = st;
      if (res_ok) exp_res = r;
    end
  endtask

  // Inputs always change 2 ns after the rising edge
  task automatic step();
    @(posedge core_clk_in);
    model();
    #2;
    check({2'b00, status_out}, {2'b00, exp_st}, "status");
    check(page_base_out, exp_st[5] ? CSR_PAGE_UPPER_BASE : CSR_PAGE_LOWER_BASE, "page");
    if (res_ok) check({2'b00, alu_result_out}, {2'b00, exp_res}, "result");
  endtask

  task automatic put(input csr_op_t op, input logic [7:0] f, input logic [7:0] w,
                     input logic wr, input logic [7:0] d, input logic [3:0] ev,
                     input csr_wake_cause_t cause);
    clk_en_in = 1'b1;
    alu_op_in = op;
    alu_operand_f_in = f;
    alu_operand_w_in = w;
    file_addr_in = CSR_STATUS_ADDR;
    file_wr_en_in = wr;
    file_wr_data_in = d;
    {reset_event_in, watchdog_clear_instr_in, sleep_instr_in, watchdog_timeout_in} = ev;
    reset_cause_in = cause;
    step();
  endtask

  task automatic wrap_up();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    #(6000 * 50);
    n_errors++;
    wrap_up();
  end

  initial begin
    repeat (12) step();
    srst_in = 1'b0;
    step();
    put(CSR_OP_NONE, 8'h00, 8'h00, 1'b1, 8'ha5, 4'h0, CSR_CAUSE_OTHER);
    put(CSR_OP_ADD, 8'h0f, 8'h01, 1'b0, 8'h00, 4'h0, CSR_CAUSE_OTHER);
    put(CSR_OP_ADD, 8'hff, 8'h01, 1'b1, 8'h00, 4'h0, CSR_CAUSE_OTHER);
    put(CSR_OP_SUB, 8'h01, 8'h02, 1'b1, 8'hff, 4'h0, CSR_CAUSE_OTHER);
    put(CSR_OP_SUB, 8'h10, 8'h01, 1'b0, 8'h00, 4'h0, CSR_CAUSE_OTHER);
    for (int i = 0; i < 9; i++) begin
      put(csr_op_t'(i), 8'h81, 8'h81, 1'b0, 8'h00, 4'h0, CSR_CAUSE_OTHER);
    end
    put(CSR_OP_NONE, 8'h00, 8'h00, 1'b0, 8'h00, 4'b0010, CSR_CAUSE_OTHER);
    put(CSR_OP_NONE, 8'h00, 8'h00, 1'b1, 8'hff, 4'b0001, CSR_CAUSE_OTHER);
    put(CSR_OP_NONE, 8'h00, 8'h00, 1'b0, 8'h00, 4'b0111, CSR_CAUSE_OTHER);
    put(CSR_OP_NONE, 8'h00, 8'h00, 1'b1, 8'h00, 4'b1000, CSR_CAUSE_PIN);
    put(CSR_OP_NONE, 8'h00, 8'h00, 1'b1, 8'hc0, 4'b1000, CSR_CAUSE_CMP);
    put(CSR_OP_NONE, 8'h00, 8'h00, 1'b0, 8'h00, 4'b1000, CSR_CAUSE_OTHER);
    // Random traffic; zero results are forced often so the zero flag toggles
    for (int n = 0; n < 3000; n++) begin
      seed = xs(seed);
      srst_in = (n == 1500);
      clk_en_in = (seed[2:0] != 3'h0);
      file_addr_in = seed[3] ? CSR_STATUS_ADDR : seed[15:8];
      file_wr_en_in = seed[4];
      file_wr_data_in = seed[23:16];
      alu_op_in = csr_op_t'(seed[27:24] % 4'h9);
      seed = xs(seed);
      alu_operand_f_in = seed[7:0];
      alu_operand_w_in = seed[16] ? seed[7:0] : seed[15:8];
      reset_event_in = (seed[19:17] == 3'h0);
      reset_cause_in = csr_wake_cause_t'(seed[21:20] % 2'h3);
      watchdog_timeout_in = (seed[24:22] == 3'h0);
      watchdog_clear_instr_in = (seed[27:25] == 3'h0);
      sleep_instr_in = (seed[30:28] == 3'h0);
      step();
    end
    wrap_up();
  end
endmodule
